// >>> shared/sadc_pkg.sv
package sadc_pkg;
   // Result width and stream
   localparam int RESULT_W     = 12;
   localparam int TOP_BIT_POS  = 11;
   localparam int BITCNT_W     = 4;
   localparam logic [BITCNT_W-1:0] BITCNT_RST = 4'h0;
   localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;

   // Clock rate
   localparam int REF_CLK_MHZ  = 200;

   // Speed grades
   localparam logic [1:0] GRADE_SLOW = 2'h0;
   localparam logic [1:0] GRADE_MID  = 2'h1;
   localparam logic [1:0] GRADE_FAST = 2'h2;

   // Conversion intervals in ns
   localparam int CONVERT_STROBE_NS_SLOW = 8000;
   localparam int CONVERT_STROBE_NS_MID  = 3000;
   localparam int CONVERT_STROBE_NS_FAST = 1500;

   // Acquisition intervals in ns
   localparam int ACQ_NS_SLOW  = 2000;
   localparam int ACQ_NS_MID   = 1000;
   localparam int ACQ_NS_FAST  = 500;

   // Cycle counts, least times rounded up
   localparam int CONVERT_STROBE_CYC_SLOW = (CONVERT_STROBE_NS_SLOW * REF_CLK_MHZ + 999) / 1000;
   localparam int CONVERT_STROBE_CYC_MID  = (CONVERT_STROBE_NS_MID * REF_CLK_MHZ + 999) / 1000;
   localparam int CONVERT_STROBE_CYC_FAST = (CONVERT_STROBE_NS_FAST * REF_CLK_MHZ + 999) / 1000;
   localparam int ACQ_CYC_SLOW  = (ACQ_NS_SLOW * REF_CLK_MHZ + 999) / 1000;
   localparam int ACQ_CYC_MID   = (ACQ_NS_MID * REF_CLK_MHZ + 999) / 1000;
   localparam int ACQ_CYC_FAST  = (ACQ_NS_FAST * REF_CLK_MHZ + 999) / 1000;
   localparam int TIMER_W       = 11;

   // Converter states
   typedef enum logic [1:0] {
      SADC_SLEEP,
      SADC_ACQUIRE,
      SADC_CONVERT
   } sadc_state_e;
endpackage : sadc_pkg

// >>> shared/sadc_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sadc_sync_if;
   logic strobe_rise;
   logic strobe_fall;
   logic strobe_level;
   logic shift_fall;
   modport src (output strobe_rise, output strobe_fall, output strobe_level, output shift_fall);
   modport dst (input strobe_rise, input strobe_fall, input strobe_level, input shift_fall);
endinterface : sadc_sync_if
`default_nettype wire

// >>> design/sadc_edge_sync.sv
`timescale 1ns/10ps
`default_nettype none
module sadc_edge_sync
(
   // Clock and reset
   input  wire logic     clk,
   input  wire logic     rst_b,
   // Raw pins
   input  wire logic     strobe_pin,
   input  wire logic     shift_pin,
   // Edge events
   sadc_sync_if.src      ev
);
   logic [2:0] strobe_r;
   logic [2:0] shift_r;

   // Two stages, then a third for edge compare
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         strobe_r <= 3'h0;
         shift_r  <= 3'h0;
      end
      else
      begin
         strobe_r <= {strobe_r[1:0], strobe_pin};
         shift_r  <= {shift_r[1:0], shift_pin};
      end
   end

   assign ev.strobe_level = strobe_r[1];
   assign ev.strobe_rise  = strobe_r[1] & ~strobe_r[2];
   assign ev.strobe_fall  = ~strobe_r[1] & strobe_r[2];
   assign ev.shift_fall   = ~shift_r[1] & shift_r[2];
endmodule : sadc_edge_sync
`default_nettype wire

// >>> design/sadc_top.sv
// Behaviour
// - Strobe rising edge starts a conversion
// - Power down automatically after conversion if strobe is still high
// - Strobe low drives serial output
// - Output changes only on shift-clock falls
// - MSB first, twelve bits, then zeros
// - Strobe rise releases output to high-Z
// - Strobe fall presents top result bit
// - Strobe low powers up, acquisition held
`timescale 1ns/10ps
`default_nettype none
module sadc_top
   import sadc_pkg::*;
(
   // Clock and reset
   input  wire logic                 REF_CLK,
   input  wire logic                 RST_B,
   // Serial link pins
   input  wire logic                 CONVERT_STROBE,
   input  wire logic                 SHIFT_CLK,
   output logic                      SERIAL_RESULT_OUT_O,
   output logic                      SERIAL_RESULT_OUT_OE,
   // Grade select and sample source
   input  wire logic [1:0]           SPEED_GRADE,
   input  wire logic [sadc_pkg::RESULT_W-1:0] SAMPLE_IN,
   // Status
   output logic                      POWERED_UP,
   output logic                      ACQUIRED,
   output logic                      CONVERT_STROBE_DONE
);
   import sadc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   sadc_sync_if ev ();

   sadc_edge_sync u_sync
   (
      .clk        (REF_CLK),
      .rst_b      (RST_B),
      .strobe_pin (CONVERT_STROBE),
      .shift_pin  (SHIFT_CLK),
      .ev         (ev)
   );

   ////////////////////////////////////////////////////////////////////////////////
   sadc_state_e              state_r;
   logic [TIMER_W-1:0]       timer_r;
   logic [TIMER_W-1:0]       convert_strobe_len;
   logic [TIMER_W-1:0]       acq_len;
   logic [RESULT_W-1:0]      hold_r;
   logic [RESULT_W-1:0]      shift_r;
   logic [BITCNT_W-1:0]      sent_r;
   logic                     oe_r;
   logic                     dout_r;
   logic                     acq_ok_r;
   logic                     done_r;
   logic                     convert_strobe_end;

   always_comb
   begin
      case (SPEED_GRADE)
         GRADE_MID:
         begin
            convert_strobe_len = TIMER_W'(CONVERT_STROBE_CYC_MID);
            acq_len  = TIMER_W'(ACQ_CYC_MID);
         end
         GRADE_FAST:
         begin
            convert_strobe_len = TIMER_W'(CONVERT_STROBE_CYC_FAST);
            acq_len  = TIMER_W'(ACQ_CYC_FAST);
         end
         default:
         begin
            convert_strobe_len = TIMER_W'(CONVERT_STROBE_CYC_SLOW);
            acq_len  = TIMER_W'(ACQ_CYC_SLOW);
         end
      endcase
   end

   assign convert_strobe_end = (state_r == SADC_CONVERT) && (timer_r == TIMER_W'(1));

   ////////////////////////////////////////////////////////////////////////////////
   // Converter sequencing; a short strobe pulse still runs the full conversion
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state_r <= SADC_SLEEP;
         timer_r <= '0;
      end
      else
      begin
         case (state_r)
            SADC_SLEEP:
            begin
               if (ev.strobe_rise)
               begin
                  state_r <= SADC_CONVERT;
                  timer_r <= convert_strobe_len;
               end
               else if (ev.strobe_fall)
               begin
                  state_r <= SADC_ACQUIRE;
                  timer_r <= acq_len;
               end
            end
            SADC_ACQUIRE:
            begin
               if (ev.strobe_rise)
               begin
                  state_r <= SADC_CONVERT;
                  timer_r <= convert_strobe_len;
               end
               else if (timer_r != '0)
               begin
                  timer_r <= timer_r - TIMER_W'(1);
               end
            end
            SADC_CONVERT:
            begin
               if (convert_strobe_end)
               begin
                  state_r <= ev.strobe_level ? SADC_SLEEP : SADC_ACQUIRE;
                  timer_r <= ev.strobe_level ? '0 : acq_len;
               end
               else
               begin
                  timer_r <= timer_r - TIMER_W'(1);
               end
            end
            default:
            begin
               state_r <= SADC_SLEEP;
               timer_r <= '0;
            end
         endcase
      end
   end

   // Acquisition readiness and done flag
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         acq_ok_r <= 1'b0;
         done_r   <= 1'b0;
      end
      else
      begin
         acq_ok_r <= (state_r == SADC_ACQUIRE) && (timer_r == '0);
         if (convert_strobe_end)
            done_r <= 1'b1;
         else if (ev.strobe_rise)
            done_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Result latch
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
         hold_r <= RESULT_RST;
      else if (convert_strobe_end)
         hold_r <= SAMPLE_IN;
   end

   // Serial shift path; reading before conversion end shows the previous result
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         shift_r <= RESULT_RST;
         sent_r  <= BITCNT_RST;
         oe_r    <= 1'b0;
         dout_r  <= 1'b0;
      end
      else if (ev.strobe_rise)
      begin
         oe_r   <= 1'b0;
         dout_r <= 1'b0;
      end
      else if (ev.strobe_fall)
      begin
         oe_r    <= 1'b1;
         dout_r  <= hold_r[TOP_BIT_POS];
         shift_r <= {hold_r[RESULT_W-2:0], 1'b0};
         sent_r  <= BITCNT_RST;
      end
      else if (oe_r && ev.shift_fall)
      begin
         // Count gates the tail to zeros even if the shift path were reloaded
         if (sent_r < BITCNT_W'(TOP_BIT_POS))
            dout_r <= shift_r[TOP_BIT_POS];
         else
            dout_r <= 1'b0;
         shift_r <= {shift_r[RESULT_W-2:0], 1'b0};
         if (sent_r != BITCNT_W'(RESULT_W))
            sent_r <= sent_r + BITCNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Host samples on shift-clock rise, 28 ns after each shift-clock fall
   assign SERIAL_RESULT_OUT_O  = dout_r;
   assign SERIAL_RESULT_OUT_OE = oe_r;
   assign POWERED_UP           = (state_r != SADC_SLEEP);
   assign ACQUIRED             = acq_ok_r;
   assign CONVERT_STROBE_DONE            = done_r;
endmodule : sadc_top
`default_nettype wire

// >>> verif/sadc_checker.sv
`timescale 1ns/10ps
`default_nettype none
module sadc_checker
   import sadc_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST_B,
   // Pins and status
   input wire logic CONVERT_STROBE,
   input wire logic SHIFT_CLK,
   input wire logic SERIAL_RESULT_OUT_O,
   input wire logic SERIAL_RESULT_OUT_OE,
   input wire logic POWERED_UP,
   input wire logic CONVERT_STROBE_DONE
);
   logic [2:0]  fall_cnt_r;
   logic [10:0] hi_cnt_r;
   default clocking @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_B);
   //////////////////////////////////////////////////
   always_ff @(posedge REF_CLK or negedge RST_B)
      if (!RST_B)
         fall_cnt_r <= 3'h7;
      else if ($fell(SHIFT_CLK))
         fall_cnt_r <= 3'h0;
      else if (fall_cnt_r != 3'h7)
         fall_cnt_r <= fall_cnt_r + 3'h1;
   // Zero until a low is seen, so a strobe high out of reset is not a pulse
   always_ff @(posedge REF_CLK or negedge RST_B)
      if (!RST_B)
         hi_cnt_r <= 11'h000;
      else if (!CONVERT_STROBE)
         hi_cnt_r <= 11'h001;
      else if (hi_cnt_r != 11'h000 && hi_cnt_r != 11'h7FF)
         hi_cnt_r <= hi_cnt_r + 11'h001;
   //////////////////////////////////////////////////
   a_start_power: assert property ($rose(CONVERT_STROBE) |-> ##[2:6] POWERED_UP)
      else $error("no conversion after strobe rise");
   a_done_clear: assert property ($rose(CONVERT_STROBE) |-> ##[2:6] !CONVERT_STROBE_DONE)
      else $error("done not cleared by strobe rise");
   a_oe_release: assert property ($rose(CONVERT_STROBE) |-> ##[2:6] !SERIAL_RESULT_OUT_OE)
      else $error("output not released");
   a_oe_enable: assert property ($fell(CONVERT_STROBE) |-> ##[2:6] SERIAL_RESULT_OUT_OE)
      else $error("output not enabled");
   a_data_edge: assert property (SERIAL_RESULT_OUT_OE && $past(SERIAL_RESULT_OUT_OE)
      && $changed(SERIAL_RESULT_OUT_O) |-> fall_cnt_r <= 3'h5)
      else $error("data changed without shift fall");
   a_convert_strobe_min: assert property ($rose(CONVERT_STROBE_DONE) && CONVERT_STROBE
      |-> hi_cnt_r >= CONVERT_STROBE_CYC_FAST)
      else $error("conversion too short");
   a_convert_strobe_max: assert property (hi_cnt_r == CONVERT_STROBE_CYC_SLOW + 12 |-> CONVERT_STROBE_DONE)
      else $error("conversion overran");
   a_auto_sleep: assert property ($rose(CONVERT_STROBE_DONE) && hi_cnt_r > 11'h008
      |-> ##[0:2] !POWERED_UP)
      else $error("no power down after conversion");
   c_done: cover property ($rose(CONVERT_STROBE_DONE));
   c_enable: cover property ($rose(SERIAL_RESULT_OUT_OE));
   c_shift: cover property (SERIAL_RESULT_OUT_OE && fall_cnt_r == 3'h0);
endmodule : sadc_checker
bind sadc_top sadc_checker u_chk (.REF_CLK(REF_CLK), .RST_B(RST_B),
   .CONVERT_STROBE(CONVERT_STROBE), .SHIFT_CLK(SHIFT_CLK), .POWERED_UP(POWERED_UP),
   .SERIAL_RESULT_OUT_O(SERIAL_RESULT_OUT_O), .SERIAL_RESULT_OUT_OE(SERIAL_RESULT_OUT_OE),
   .CONVERT_STROBE_DONE(CONVERT_STROBE_DONE));
`default_nettype wire

// >>> verif/sadc_host.sv
`timescale 1ns/10ps
`default_nettype none
module sadc_host
(
   // Link pins
   output logic     strobe,
   output logic     sck,
   input wire logic sdo_o,
   input wire logic sdo_oe
);
   logic sdo_last;
   logic sdo_w;
   // A released line shows the inverse of its last level, never a stale copy
   always @(sdo_o or sdo_oe)
      if (sdo_oe)
         sdo_last = sdo_o;
   assign sdo_w = sdo_oe ? sdo_o : ~sdo_last;
   initial
   begin
      strobe = 1'b0;
      sck = 1'b0;
   end
   task automatic convert(input int ns);
      strobe = 1'b1;
      #(ns + 100);
   endtask : convert
   // Low time 28 ns leaves room for the sync delay before capture
   task automatic clocks(input int n, inout logic [15:0] w);
      repeat (n)
      begin
         sck = 1'b1;
         w = {w[14:0], sdo_w};
         #20;
         sck = 1'b0;
         #28;
      end
   endtask : clocks
   task automatic frame(input int n, input int acq, output logic [15:0] w);
      w = 16'h0000;
      strobe = 1'b0;
      #100;
      clocks(n, w);
      #(acq + 50);
   endtask : frame
endmodule : sadc_host
`default_nettype wire

// >>> verif/tb_sampling_adc_serial_readout.sv
`timescale 1ns/10ps
`default_nettype none
module tb_sampling_adc_serial_readout;
   import sadc_pkg::*;
   typedef struct {logic [1:0] g; logic [11:0] s; int convert_strobe; int acq; logic [15:0] e;} sadc_row_s;
   logic        ref_clk, rst_b, strobe, sck, sdo_o, sdo_oe, pwr, acq_done, convert_strobe_done;
   logic [1:0]  grade;
   logic [11:0] sample;
   logic [15:0] word;
   int          err_total, comparisons;
   sadc_row_s   rows [4] = '{'{GRADE_SLOW, 12'hA5C, CONVERT_STROBE_NS_SLOW, ACQ_NS_SLOW, 16'hA5C0},
      '{GRADE_MID, 12'h3F1, CONVERT_STROBE_NS_MID, ACQ_NS_MID, 16'h3F10},
      '{GRADE_FAST, 12'hFFF, CONVERT_STROBE_NS_FAST, ACQ_NS_FAST, 16'hFFF0},
      '{2'h3, 12'h801, CONVERT_STROBE_NS_SLOW, ACQ_NS_SLOW, 16'h8010}};
   sadc_top u_dut (.REF_CLK(ref_clk), .RST_B(rst_b), .CONVERT_STROBE(strobe), .SHIFT_CLK(sck),
      .SERIAL_RESULT_OUT_O(sdo_o), .SERIAL_RESULT_OUT_OE(sdo_oe), .SPEED_GRADE(grade),
      .SAMPLE_IN(sample), .POWERED_UP(pwr), .ACQUIRED(acq_done), .CONVERT_STROBE_DONE(convert_strobe_done));
   sadc_host u_host (.strobe(strobe), .sck(sck), .sdo_o(sdo_o), .sdo_oe(sdo_oe));
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      comparisons++;
      if (s !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic test_done;
      if (err_total == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   initial
   begin
      #300000;
      err_total++;
      test_done();
   end
   initial
   begin
      rst_b = 1'b0;
      grade = GRADE_FAST;
      sample = 12'h000;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      foreach (rows[i])
      begin
         @(posedge ref_clk);
         grade <= rows[i].g;
         sample <= rows[i].s;
         // Host pins move on the falling edge, clear of the sampling edge
         @(negedge ref_clk);
         u_host.convert(rows[i].convert_strobe);
         // Input moves after the end of conversion; the latched value must win
         @(posedge ref_clk) sample <= ~rows[i].s;
         chk("done", 16'h0001, 16'(convert_strobe_done));
         chk("powered", 16'h0000, 16'(pwr));
         chk("oe", 16'h0000, 16'(sdo_oe));
         @(negedge ref_clk);
         u_host.frame(16, rows[i].acq, word);
         chk("word", rows[i].e, word);
         chk("acquired", 16'h0001, 16'(acq_done));
         chk("oe", 16'h0001, 16'(sdo_oe));
      end
      // Shift clocks while the strobe is high are ignored; 12 clocks give bare data
      @(posedge ref_clk) sample <= 12'h5A3;
      grade <= GRADE_FAST;
      @(negedge ref_clk);
      u_host.convert(CONVERT_STROBE_NS_FAST);
      u_host.clocks(5, word);
      u_host.frame(12, ACQ_NS_FAST, word);
      chk("refused", 16'h05A3, word);
      // Reset in mid-conversion clears status and result
      u_host.convert(0);
      @(posedge ref_clk) rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("rst oe", 16'h0000, {14'h0, sdo_oe, convert_strobe_done});
      rst_b <= 1'b1;
      // Strobe high through reset starts a conversion; an early read shows the reset result
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      u_host.frame(16, ACQ_NS_FAST, word);
      chk("rst word", 16'h0000, word);
      test_done();
   end
endmodule : tb_sampling_adc_serial_readout
`default_nettype wire
